// File: verification/ssp_core_monitor.sv
// checker for the serial port core, watching top-level ports only
// assumes one clock domain and the active-low reset of the core
`timescale 1ns/10ps
module ssp_core_monitor
(
   input wire logic       CLOCK, RST_B, CLK_EDGE, INPUT_SAMPLE_PHASE, SLEEP, BUF_WR, BUF_RD,
   input wire logic [3:0] PORT_MODE_FIELD,
   input wire logic [7:0] PORT_DATA_BUFFER, PORT_STATUS_REG,
   input wire logic       BUFFER_FULL_FLAG, WRITE_COLLISION_FLAG, PORT_IRQ_FLAG,
   input wire logic       SCK_O, SDO_OE, SS_B, SCL_I, SDA_O, SDA_OE
);
   // ---------------------------------------------
   // pin and flag relations
   // ---------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sda_pull_only_a: assert property (SDA_OE |-> !SDA_O)
      else $error("sda driven high");
   // select pin passes two flops, so allow four cycles
   sdo_float_a: assert property ((PORT_MODE_FIELD == 4'h4 && SS_B) [*4] |-> !SDO_OE)
      else $error("sdo driven while deselected");
   bf_irq_a: assert property ($rose(BUFFER_FULL_FLAG) |-> PORT_IRQ_FLAG)
      else $error("byte loaded without irq");
   write_collision_flag_keep_a: assert property (BUF_WR && WRITE_COLLISION_FLAG |=>
      WRITE_COLLISION_FLAG && $stable(PORT_DATA_BUFFER)) else $error("collision write landed");
   status_echo_a: assert property (PORT_STATUS_REG[0] == BUFFER_FULL_FLAG
      && PORT_STATUS_REG[7:6] == {INPUT_SAMPLE_PHASE, CLK_EDGE}) else $error("status mismatch");
   bf_hold_a: assert property (BUFFER_FULL_FLAG && !BUF_RD |=> BUFFER_FULL_FLAG)
      else $error("buffer full dropped");
   sleep_freeze_a: assert property ((PORT_MODE_FIELD == 4'hA && SLEEP) [*2] |-> $stable(SCK_O))
      else $error("master clock ran in sleep");
   sda_change_a: assert property ($changed(SDA_OE) |-> !SCL_I)
      else $error("sda moved with scl high");
   cover property ($rose(BUFFER_FULL_FLAG));
   cover property ($rose(WRITE_COLLISION_FLAG));
   cover property ($rose(SDA_OE));
endmodule
bind ssp_core ssp_core_monitor mon (.CLOCK, .RST_B, .CLK_EDGE, .INPUT_SAMPLE_PHASE, .SLEEP,
   .BUF_WR, .BUF_RD, .PORT_MODE_FIELD, .PORT_DATA_BUFFER, .PORT_STATUS_REG, .BUFFER_FULL_FLAG,
   .WRITE_COLLISION_FLAG, .PORT_IRQ_FLAG, .SCK_O, .SDO_OE, .SS_B, .SCL_I, .SDA_O, .SDA_OE);

// File: verification/ssp_far_end.sv
// far-side model: an SPI master and a two-wire master driving the pins
// assumes pins are asynchronous to CLOCK; half period slow enough for sync
`timescale 1ns/10ps
module ssp_far_end
(
   output logic      sck, sdi, ss_b, scl,
   output wire       sda,
   input  wire logic sda_oe
);
   localparam int H = 400;  // half period, ten core cycles
   logic sda_drv;           // master's own pull on sda
   logic [7:0] rd;          // bits seen on sda at each clock rise
   assign sda = sda_drv & !sda_oe;
   initial {sck, sdi, ss_b, scl, sda_drv} = 5'h0B;
   // clock n bits MSb first, then deselect and leave sdi moving
   task automatic spi_bits(input logic [7:0] b, input int n);
      ss_b = 1'h0;
      for (int i = 0; i < n; i++) begin sdi = b[7-i]; #H sck = 1; #H sck = 0; end
      #H ss_b = 1'h1;
      sdi = ~sdi;
      #H; // select stays high long enough for the core to see it
   endtask
   task automatic i2c_start; sda_drv = 1; #H scl = 1; #H sda_drv = 0; #H scl = 0; endtask
   task automatic i2c_stop; sda_drv = 0; #H scl = 1; #H sda_drv = 1; #H; endtask
   // data only moves while scl is low; ack read on ninth high phase
   task automatic i2c_byte(input logic [7:0] b, output logic ack);
      for (int i = 0; i < 8; i++)
      begin
         sda_drv = b[7-i]; #H scl = 1; rd[7-i] = sda; #H scl = 0;
      end
      sda_drv = 1; #H scl = 1; ack = !sda; #H scl = 0;
   endtask
endmodule

// File: verification/tb_ssp_core.sv
// self-checking bench for the serial port core
// assumes the far-end model drives all serial pins
`timescale 1ns/10ps
module tb_ssp_core;
   import ssp_pkg::*;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
   logic clk, rst_b, en, cke, sleep, wr, rd, cclr, iclr, ack;
   logic [3:0] mode;
   logic [7:0] own, msk, wd, dbuf, st;
   logic       bf, write_collision_flag, irq, sdo_oe, sda_oe, sck, sdi, ss_b, scl, sdo, sck_oe;
   wire        sda;
   int         num_errors = 0, checked = 0;
   ssp_far_end far (.sck(sck), .sdi(sdi), .ss_b(ss_b), .scl(scl), .sda(sda), .sda_oe(sda_oe));
   ssp_core dut (.CLOCK(clk), .RST_B(rst_b), .PORT_EN(en), .PORT_MODE_FIELD(mode), .CLK_POL(1'h0),
      .CLK_EDGE(cke), .INPUT_SAMPLE_PHASE(1'h0), .SLEEP(sleep), .OWN_ADDRESS_OR_BAUD_RELOAD(own),
      .SLAVE_ADDRESS_MASK(msk), .BUF_WR(wr), .BUF_WDATA(wd), .BUF_RD(rd), .COLLISION_CLR(cclr),
      .IRQ_CLR(iclr), .PORT_DATA_BUFFER(dbuf), .PORT_STATUS_REG(st), .BUFFER_FULL_FLAG(bf),
      .WRITE_COLLISION_FLAG(write_collision_flag), .PORT_IRQ_FLAG(irq), .SCK_I(sck), .SCK_O(), .SCK_OE(sck_oe),
      .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .SS_B(ss_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
      .SDA_OE(sda_oe));
   initial begin clk = 0; forever #20 clk = ~clk; end
   task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
   // one-cycle software strobe with write data
   task automatic sw(input logic w, input logic r, input logic c, input logic [7:0] d);
      @(posedge clk) {wr, rd, cclr, iclr, wd} <= {w, r, c, c, d};
      @(posedge clk) {wr, rd, cclr, iclr} <= 4'h0;
      @(negedge clk); // flags updated at the edge are settled before any compare
   endtask
   task automatic stop_test;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, well beyond the few tens of microseconds needed
   initial begin #300000; num_errors++; stop_test(); end
   initial begin
      {en, cke, sleep, wr, rd, cclr, iclr, mode, wd} = 0;
      {own, msk, rst_b} = {8'h50, 8'hF0, 1'h0};
      cyc(5);
      rst_b <= 1'h1;
      cyc(4);
      {en, mode, cke} <= {1'h1, 4'h4, 1'h1};
      cyc(4);
      far.spi_bits(8'hFF, 4);   // half byte, then select high drops it
      sleep <= 1'h1;
      far.spi_bits(8'hA5, 8);
      cyc(6);
      `CHK("spi byte", 8'hA5, dbuf)
      `CHK("spi flags", 3'h7, {bf, irq, st[0]})
      `CHK("sdo released", 1'h0, sdo_oe)
      sw(0, 1, 1, 0);
      `CHK("full cleared", 1'h0, bf)
      {mode, own, sleep} <= {4'hA, 8'h00, 1'h0};
      cyc(2);
      sw(1, 0, 0, 8'h3C);
      sw(1, 0, 0, 8'hC3);
      `CHK("collision", 1'h1, write_collision_flag)
      sw(1, 0, 0, 8'h99);
      `CHK("tx buffer", 8'h3C, dbuf)
      `CHK("collision held", 1'h1, write_collision_flag)
      `CHK("master drives clock", 1'h1, sck_oe)
      `CHK("third bit out", 1'h1, sdo)
      sleep <= 1'h1;
      cyc(6);
      sleep <= 1'h0;
      cyc(60);
      sw(0, 1, 1, 0);
      `CHK("collision clear", 1'h0, write_collision_flag)
      {mode, own} <= {4'h6, 8'h50};
      cyc(4);
      far.i2c_start();
      far.i2c_byte(8'h5A, ack);
      `CHK("masked match ack", 1'h1, ack)
      `CHK("address byte", 8'h5A, dbuf)
      far.i2c_byte(8'h11, ack);
      cyc(6);
      `CHK("data ack", 1'h1, ack)
      `CHK("data byte", 8'h11, dbuf)
      far.i2c_start();
      far.i2c_byte(8'h30, ack);
      `CHK("no match", 1'h0, ack)
      far.i2c_stop();
      cyc(6);
      `CHK("stop seen", 1'h1, st[4])
      far.i2c_start();
      fork
         far.i2c_byte(8'h51, ack);
         begin
            wait (sda_oe);
            sw(1, 0, 0, 8'hC6);
         end
      join
      `CHK("read address ack", 1'h1, ack)
      far.i2c_byte(8'hFF, ack);
      `CHK("read byte", 8'hC6, far.rd)
      `CHK("slave released", 1'h0, ack)
      far.i2c_stop();
      cyc(6);
      `CHK("read flags", 2'h3, {st[2], st[5]})
      stop_test();
   end
endmodule

// File: verilog/ssp_core.sv
// synchronous serial port core: SPI master/slave and two-wire slave
// assumes CLOCK at 25 MHz; software side is same-clock logic; pins are asynchronous
`timescale 1ns/10ps
`include "ssp_core_cfg.svh"
module ssp_core
   import ssp_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST_B,
   input  wire logic        PORT_EN,
   input  wire logic [3:0]  PORT_MODE_FIELD,
   input  wire logic        CLK_POL,
   input  wire logic        CLK_EDGE,
   input  wire logic        INPUT_SAMPLE_PHASE,
   input  wire logic        SLEEP,
   input  wire logic [7:0]  OWN_ADDRESS_OR_BAUD_RELOAD,
   input  wire logic [7:0]  SLAVE_ADDRESS_MASK,
   input  wire logic        BUF_WR,
   input  wire logic [7:0]  BUF_WDATA,
   input  wire logic        BUF_RD,
   input  wire logic        COLLISION_CLR,
   input  wire logic        IRQ_CLR,
   output logic      [7:0]  PORT_DATA_BUFFER,
   output logic      [7:0]  PORT_STATUS_REG,
   output logic             BUFFER_FULL_FLAG,
   output logic             WRITE_COLLISION_FLAG,
   output logic             PORT_IRQ_FLAG,
   input  wire logic        SCK_I,
   output logic             SCK_O,
   output logic             SCK_OE,
   input  wire logic        SDI,
   output logic             SDO,
   output logic             SDO_OE,
   input  wire logic        SS_B,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE
);

   // ----------------------------------------------------------------
   // reset release through two flops
   // ----------------------------------------------------------------
   logic rst_meta_ff;   // first stage
   logic rst_n;         // released reset used everywhere

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   ssp_sync_if #(.W(`SSP_PIN_CNT)) pins ();

   assign pins.raw = {SDA_I, SCL_I, SS_B, SDI, SCK_I};

   ssp_pin_sync #(.W(`SSP_PIN_CNT)) u_sync
   (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .p     (pins)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  sr_ff,   nxt_sr;     // shift register, not visible to software
   logic [7:0]  buf_ff,  nxt_buf;    // data buffer
   logic [3:0]  cnt_ff,  nxt_cnt;    // bit counter
   logic [3:0]  half_ff, nxt_half;   // master half periods done
   logic [7:0]  div_ff,  nxt_div;    // master baud divider
   logic        msck_ff, nxt_msck;   // master clock level
   logic        run_ff,  nxt_run;    // master transfer running
   logic        sdo_ff,  nxt_sdo;    // serial data out bit
   logic        sda_ff,  nxt_sda;    // pulling data line low
   logic        bf_ff,   nxt_bf;     // buffer full
   logic        write_collision_flag_ff, nxt_write_collision_flag;   // write collision
   logic        irq_ff,  nxt_irq;    // port interrupt flag
   logic        rw_ff,   nxt_rw;     // direction of current transfer
   logic        da_ff,   nxt_da;     // last byte was data, not address
   logic        s_ff,    nxt_s;      // start seen last
   logic        p_ff,    nxt_p;      // stop seen last
   ssp_i2c_st_t st_ff,   nxt_st;     // two-wire sequencer

   // ----------------------------------------------------------------
   // mode decode and edge selection
   // ----------------------------------------------------------------
   logic is_mst;     // SPI master
   logic is_slv;     // SPI slave, either select option
   logic is_i2c;     // two-wire slave
   logic ss_reset;   // select high with select control on
   logic tick;       // master half-period enable
   logic to_act;     // clock leaves idle level
   logic to_idle;    // clock returns to idle level
   logic samp;       // sample edge
   logic shout;      // output edge
   logic busy;       // transfer in flight
   logic scl_hi;     // clock line high
   logic start_c;    // start condition seen
   logic stop_c;     // stop condition seen
   logic addr_hit;   // masked own-address match

   assign is_mst   = PORT_MODE_FIELD == `SSP_MODE_SPI_MST;
   assign is_slv   = (PORT_MODE_FIELD == `SSP_MODE_SPI_SLV_SS) |
                     (PORT_MODE_FIELD == `SSP_MODE_SPI_SLV);
   assign is_i2c   = PORT_MODE_FIELD == `SSP_MODE_I2C_SLV;
   assign ss_reset = (PORT_MODE_FIELD == `SSP_MODE_SPI_SLV_SS) &
                     pins.lvl[`SSP_PIN_SS];

   // the divider stands still in sleep so a master byte freezes mid-way
   assign tick     = is_mst & run_ff & ~SLEEP & (div_ff == `SSP_BYTE_RST);

   // slave edges come from the pin; sleep does not gate them
   assign to_act   = is_mst ? (tick & (msck_ff == CLK_POL)) :
                     (CLK_POL ? pins.fall[`SSP_PIN_SCK] : pins.rise[`SSP_PIN_SCK]);
   assign to_idle  = is_mst ? (tick & (msck_ff != CLK_POL)) :
                     (CLK_POL ? pins.rise[`SSP_PIN_SCK] : pins.fall[`SSP_PIN_SCK]);
   assign samp     = CLK_EDGE ? to_act : to_idle;
   assign shout    = CLK_EDGE ? to_idle : to_act;

   assign busy     = run_ff | (cnt_ff != `SSP_CNT_RST) | (is_i2c & (st_ff == SSP_I_TX));

   // released line reads one, pulled line reads zero
   assign scl_hi   = pins.lvl[`SSP_PIN_SCL];
   assign start_c  = pins.fall[`SSP_PIN_SDA] & scl_hi;
   assign stop_c   = pins.rise[`SSP_PIN_SDA] & scl_hi;
   assign addr_hit = ((sr_ff[7:1] ^ OWN_ADDRESS_OR_BAUD_RELOAD[7:1]) &
                      SLAVE_ADDRESS_MASK[7:1]) == 7'h00;

   // ----------------------------------------------------------------
   // next-state logic for the whole port
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_sr   = sr_ff;
      nxt_buf  = buf_ff;
      nxt_cnt  = cnt_ff;
      nxt_half = half_ff;
      nxt_div  = div_ff;
      nxt_msck = msck_ff;
      nxt_run  = run_ff;
      nxt_sdo  = sdo_ff;
      nxt_sda  = sda_ff;
      nxt_bf   = bf_ff;
      nxt_write_collision_flag = write_collision_flag_ff;
      nxt_irq  = irq_ff;
      nxt_rw   = rw_ff;
      nxt_da   = da_ff;
      nxt_s    = s_ff;
      nxt_p    = p_ff;
      nxt_st   = st_ff;

      // software clears first, so a hardware set in the same cycle wins
      if (BUF_RD)
         nxt_bf = 1'b0;
      if (COLLISION_CLR)
         nxt_write_collision_flag = 1'b0;
      if (IRQ_CLR)
         nxt_irq = 1'b0;

      if (!PORT_EN)
      begin
         // disabled: counters and drivers fall back to idle
         nxt_cnt  = `SSP_CNT_RST;
         nxt_run  = 1'b0;
         nxt_msck = CLK_POL;
         nxt_sda  = 1'b0;
         nxt_st   = SSP_I_IDLE;
      end
      else if (is_mst | is_slv)
      begin
         // master baud divider reloads from the address register
         if (is_mst & run_ff & ~SLEEP)
         begin
            if (tick)
            begin
               nxt_div  = OWN_ADDRESS_OR_BAUD_RELOAD;
               nxt_msck = ~msck_ff;
               nxt_half = half_ff + 4'h1;
               if (half_ff == `SSP_LAST_HALF)
                  nxt_run = 1'b0;
            end
            else
               nxt_div = div_ff - 8'h01;
         end
         if (ss_reset)
            nxt_cnt = `SSP_CNT_RST;
         else if (samp & (run_ff | is_slv))
         begin
            nxt_sr = {sr_ff[6:0], pins.lvl[`SSP_PIN_SDI]};
            if (cnt_ff == `SSP_LAST_BIT)
            begin
               // byte done: hand over and free the shifter
               nxt_buf = {sr_ff[6:0], pins.lvl[`SSP_PIN_SDI]};
               nxt_bf  = 1'b1;
               nxt_irq = 1'b1;
               nxt_cnt = `SSP_CNT_RST;
            end
            else
               nxt_cnt = cnt_ff + 4'h1;
         end
         else if (shout & (run_ff | is_slv))
            nxt_sdo = sr_ff[7];
      end
      else if (is_i2c)
      begin
         if (start_c)
         begin
            // start or repeated start: keep the bus, take a new address
            nxt_st  = SSP_I_ADDR;
            nxt_cnt = `SSP_CNT_RST;
            nxt_sda = 1'b0;
            nxt_s   = 1'b1;
            nxt_p   = 1'b0;
         end
         else if (stop_c)
         begin
            nxt_st  = SSP_I_IDLE;
            nxt_cnt = `SSP_CNT_RST;
            nxt_sda = 1'b0;
            nxt_s   = 1'b0;
            nxt_p   = 1'b1;
         end
         else
         begin
            case (st_ff)
               SSP_I_ADDR, SSP_I_RX:
               begin
                  // sample on clock rise, act after the eighth fall
                  if (pins.rise[`SSP_PIN_SCL] & (cnt_ff != `SSP_BYTE_BITS))
                  begin
                     nxt_sr  = {sr_ff[6:0], pins.lvl[`SSP_PIN_SDA]};
                     nxt_cnt = cnt_ff + 4'h1;
                  end
                  else if (pins.fall[`SSP_PIN_SCL] & (cnt_ff == `SSP_BYTE_BITS))
                  begin
                     nxt_cnt = `SSP_CNT_RST;
                     if ((st_ff == SSP_I_RX) | addr_hit)
                     begin
                        nxt_buf = sr_ff;
                        nxt_bf  = 1'b1;
                        nxt_irq = 1'b1;
                        nxt_sda = 1'b1;
                        nxt_st  = SSP_I_ACK;
                        nxt_da  = st_ff == SSP_I_RX;
                        if (st_ff == SSP_I_ADDR)
                           nxt_rw = sr_ff[0];
                     end
                     else
                        nxt_st = SSP_I_IGNORE;
                  end
               end
               SSP_I_ACK:
               begin
                  // end of the acknowledge slot: change data only while low
                  if (pins.fall[`SSP_PIN_SCL])
                  begin
                     nxt_sda = rw_ff & ~sr_ff[7];
                     nxt_st  = rw_ff ? SSP_I_TX : SSP_I_RX;
                     nxt_cnt = `SSP_CNT_RST;
                  end
               end
               SSP_I_TX:
               begin
                  if (pins.fall[`SSP_PIN_SCL])
                  begin
                     if (cnt_ff == `SSP_LAST_BIT)
                     begin
                        nxt_sda = 1'b0;
                        nxt_cnt = `SSP_CNT_RST;
                        nxt_st  = SSP_I_TXACK;
                        nxt_irq = 1'b1;
                        nxt_da  = 1'b1;
                     end
                     else
                     begin
                        nxt_sr  = {sr_ff[6:0], 1'b0};
                        nxt_sda = ~sr_ff[6];
                        nxt_cnt = cnt_ff + 4'h1;
                     end
                  end
               end
               SSP_I_TXACK:
               begin
                  // master answer on the ninth rise: low asks for more
                  if (pins.rise[`SSP_PIN_SCL])
                     nxt_st = pins.lvl[`SSP_PIN_SDA] ? SSP_I_IGNORE : SSP_I_ACK;
               end
               default:
               begin
                  nxt_sda = 1'b0;
               end
            endcase
         end
      end

      // single-buffered transmit; a write mid-transfer is thrown away
      if (BUF_WR)
      begin
         if (busy | write_collision_flag_ff)
            nxt_write_collision_flag = 1'b1;
         else
         begin
            nxt_buf = BUF_WDATA;
            nxt_sr  = BUF_WDATA;
            nxt_sdo = BUF_WDATA[7];
            if (is_mst & PORT_EN)
            begin
               nxt_run  = 1'b1;
               nxt_div  = OWN_ADDRESS_OR_BAUD_RELOAD;
               nxt_half = `SSP_CNT_RST;
               nxt_msck = CLK_POL;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sr_ff   <= `SSP_BYTE_RST;
         buf_ff  <= `SSP_BYTE_RST;
         cnt_ff  <= `SSP_CNT_RST;
         half_ff <= `SSP_CNT_RST;
         div_ff  <= `SSP_BYTE_RST;
         msck_ff <= 1'b0;
         run_ff  <= 1'b0;
         sdo_ff  <= 1'b0;
         sda_ff  <= 1'b0;
         bf_ff   <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         irq_ff  <= 1'b0;
         rw_ff   <= 1'b0;
         da_ff   <= 1'b0;
         s_ff    <= 1'b0;
         p_ff    <= 1'b0;
         st_ff   <= SSP_I_IDLE;
      end
      else
      begin
         sr_ff   <= nxt_sr;
         buf_ff  <= nxt_buf;
         cnt_ff  <= nxt_cnt;
         half_ff <= nxt_half;
         div_ff  <= nxt_div;
         msck_ff <= nxt_msck;
         run_ff  <= nxt_run;
         sdo_ff  <= nxt_sdo;
         sda_ff  <= nxt_sda;
         bf_ff   <= nxt_bf;
         write_collision_flag_ff <= nxt_write_collision_flag;
         irq_ff  <= nxt_irq;
         rw_ff   <= nxt_rw;
         da_ff   <= nxt_da;
         s_ff    <= nxt_s;
         p_ff    <= nxt_p;
         st_ff   <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PORT_DATA_BUFFER     = buf_ff;
   assign BUFFER_FULL_FLAG     = bf_ff;
   assign WRITE_COLLISION_FLAG = write_collision_flag_ff;
   assign PORT_IRQ_FLAG        = irq_ff;

   // top two bits echo the software settings, bit 1 reads zero, the rest is hardware state
   always_comb
   begin
      PORT_STATUS_REG                = 8'h00;
      PORT_STATUS_REG[`SSP_ST_BF]    = bf_ff;
      PORT_STATUS_REG[`SSP_ST_RW]    = rw_ff;
      PORT_STATUS_REG[`SSP_ST_START] = s_ff;
      PORT_STATUS_REG[`SSP_ST_STOP]  = p_ff;
      PORT_STATUS_REG[`SSP_ST_DA]    = da_ff;
      PORT_STATUS_REG[`SSP_ST_CKE]   = CLK_EDGE;
      PORT_STATUS_REG[`SSP_ST_SMP]   = INPUT_SAMPLE_PHASE;
   end

   assign SCK_O  = msck_ff;
   assign SCK_OE = PORT_EN & is_mst;
   assign SDO    = sdo_ff;
   // with select control on, floats once select is seen high, even mid-byte
   assign SDO_OE = PORT_EN & (is_mst | (is_slv & ~ss_reset));
   // data line is only ever pulled low, never driven high
   assign SDA_O  = 1'b0;
   assign SDA_OE = PORT_EN & is_i2c & sda_ff;

endmodule

// File: verilog/ssp_core_cfg.svh
// constants of the synchronous serial port core: mode codes, widths, reset values, bit positions
// assumes inclusion by bare name from the package and the core; definitions only
//
// What this block does
// - SS high resets SPI slave in mode 0100
// - SPI master freezes in sleep, then resumes
// - SPI slave shifts during sleep, flags eight bits
// - start is data falling while clock high
// - MSb first, then direction bit, one reads
// - addressed receiver pulls data low to acknowledge
// - data changes only while clock is low
// - slave acknowledges every byte of master write
// - master acknowledges every byte it reads but the last
// - stop is data rising while clock high
// - receiving master ends with stop, not acknowledge
// - repeated start may replace stop or final acknowledge
// - combined messages without releasing the bus
// - both lines open drain, released reads one
// - control registers read/write, status low six read-only
// - address register: own address, or baud reload
// - mask selects which address bits must match
// - received byte moves to buffer, flag set
// - buffer write loads buffer and shift register
// - write while busy discarded, collision flag set
// - buffer full set on receive, cleared by read
// - SS high floats the slave data output in mode 0100
// - after eighth fall, sender releases, samples acknowledge
`ifndef SSP_CORE_CFG_SVH
`define SSP_CORE_CFG_SVH

// ----------------------------------------------------------------
// port mode field codes
// ----------------------------------------------------------------
`define SSP_MODE_SPI_MST     4'hA
`define SSP_MODE_SPI_SLV_SS  4'h4
`define SSP_MODE_SPI_SLV     4'h5
`define SSP_MODE_I2C_SLV     4'h6

// ----------------------------------------------------------------
// widths, counts and reset values
// ----------------------------------------------------------------
`define SSP_LAST_BIT         4'h7
`define SSP_BYTE_BITS        4'h8
`define SSP_LAST_HALF        4'hF
`define SSP_BYTE_RST         8'h00
`define SSP_CNT_RST          4'h0

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define SSP_ST_BF            0
`define SSP_ST_UA            1
`define SSP_ST_RW            2
`define SSP_ST_START         3
`define SSP_ST_STOP          4
`define SSP_ST_DA            5
`define SSP_ST_CKE           6
`define SSP_ST_SMP           7

// ----------------------------------------------------------------
// synchronised pin vector positions
// ----------------------------------------------------------------
`define SSP_PIN_SCK          0
`define SSP_PIN_SDI          1
`define SSP_PIN_SS           2
`define SSP_PIN_SCL          3
`define SSP_PIN_SDA          4
`define SSP_PIN_CNT          5

`endif

// File: verilog/ssp_pin_sync.sv
// two-flop synchroniser with edge pulses for every asynchronous pin
// assumes synchronised active-low reset; pins idle high after reset
`timescale 1ns/10ps
module ssp_pin_sync #(parameter int W = 5)
(
   input  wire logic   clk,
   input  wire logic   rst_n,
   ssp_sync_if.syncer  p
);
   logic [W-1:0] meta_ff;   // first stage, read only by sync_ff
   logic [W-1:0] sync_ff;   // safe level
   logic [W-1:0] old_ff;    // previous safe level for edges

   // ----------------------------------------------------------------
   // one chain per pin; resets high since both buses idle high
   // ----------------------------------------------------------------
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_ff[i] <= 1'b1;
            sync_ff[i] <= 1'b1;
            old_ff[i]  <= 1'b1;
         end
         else
         begin
            meta_ff[i] <= p.raw[i];
            sync_ff[i] <= meta_ff[i];
            old_ff[i]  <= sync_ff[i];
         end
      end
      assign p.lvl[i]  = sync_ff[i];
      assign p.rise[i] = sync_ff[i] & ~old_ff[i];
      assign p.fall[i] = ~sync_ff[i] & old_ff[i];
   end
endmodule

// File: verilog/ssp_pkg.sv
// types shared by the serial port core
// assumes the cfg header sits on the include path
package ssp_pkg;
`include "ssp_core_cfg.svh"

   // ----------------------------------------------------------------
   // two-wire slave sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SSP_I_IDLE,
      SSP_I_ADDR,
      SSP_I_RX,
      SSP_I_ACK,
      SSP_I_TX,
      SSP_I_TXACK,
      SSP_I_IGNORE
   } ssp_i2c_st_t;

endpackage

// File: verilog/ssp_sync_if.sv
// carrier between the pin synchroniser and the core
// assumes one clock; raw side is asynchronous pins
`timescale 1ns/10ps
interface ssp_sync_if #(parameter int W = 5);
   logic [W-1:0] raw;   // pins as they arrive
   logic [W-1:0] lvl;   // two-flop synchronised level
   logic [W-1:0] rise;  // one-cycle pulse on rising level
   logic [W-1:0] fall;  // one-cycle pulse on falling level

   modport syncer (input raw, output lvl, output rise, output fall);
   modport user   (output raw, input lvl, input rise, input fall);
endinterface
